// ===== logic/iodr_consts.svh
`ifndef IODR_CONSTS_SVH
`define IODR_CONSTS_SVH

// Register byte offsets
`define IODR_IDX_SUPPLY 8'h02
`define IODR_IDX_ACCEL_Y 8'h0c
`define IODR_IDX_ACCEL_Z 8'h0e
`define IODR_IDX_MAG_X 8'h10
`define IODR_IDX_MAG_Y 8'h12
`define IODR_IDX_MAG_Z 8'h14
`define IODR_IDX_PRESS_HIGH 8'h16
`define IODR_IDX_PRESS_LOW 8'h18
`define IODR_IDX_TEMP 8'h1a

// Field positions and widths
`define IODR_BIT_NEW 15
`define IODR_BIT_ERR 14
`define IODR_W14 14
`define IODR_W12 12
`define IODR_W8 8

// Fill value under the fields of each iodr_word_fmt word
`define IODR_RESET_WORD 16'h0000
// Cycles the bus slave spends in its wait state; its answer comes 2 cycles after the request is seen
`define IODR_WAIT_CYCLES 1

`endif

// ===== logic/iodr_pkg.sv
package iodr_pkg;

	typedef enum logic [3:0] {
		IODR_CH_SUPPLY = 4'h0,
		IODR_CH_ACCEL_Y = 4'h1,
		IODR_CH_ACCEL_Z = 4'h2,
		IODR_CH_MAG_X = 4'h3,
		IODR_CH_MAG_Y = 4'h4,
		IODR_CH_MAG_Z = 4'h5,
		IODR_CH_PRESS_HIGH = 4'h6,
		IODR_CH_PRESS_LOW = 4'h7,
		IODR_CH_TEMP = 4'h8,
		IODR_CH_NONE = 4'hf
	} iodr_chan_e;

	typedef enum logic [2:0] {
		IODR_ST_IDLE = 3'b001,
		IODR_ST_WAIT = 3'b010,
		IODR_ST_DONE = 3'b100
	} iodr_state_e;

	// Sample handed in by the sensor front end
	typedef struct packed {
		logic [13:0] accel_y;
		logic [13:0] accel_z;
		logic [13:0] mag_x;
		logic [13:0] mag_y;
		logic [13:0] mag_z;
		logic [21:0] pressure;
		logic [11:0] temperature;
		logic [11:0] supply;
	} iodr_sample_s;

	// Avalon-MM request
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} iodr_avm_req_s;

	typedef logic [15:0] iodr_word_t;

endpackage

// ===== logic/iodr_word_fmt.sv
`timescale 1ns/10ps
`include "iodr_consts.svh"

module iodr_word_fmt
	import iodr_pkg::*;
#(
	parameter int FIELD_W = 14
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sample side
	input wire logic load,
	input wire logic [FIELD_W-1:0] field,
	// Status side
	input wire logic alarm,
	input wire logic read_ack,
	// Formatted word
	output iodr_word_t word
);

	logic [FIELD_W-1:0] data_reg;
	logic new_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			data_reg <= '0;
		end else if (load) begin
			data_reg <= field;
		end
	end

	// Load wins over a read in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			new_reg <= 1'b0;
		end else if (load) begin
			new_reg <= 1'b1;
		end else if (read_ack) begin
			new_reg <= 1'b0;
		end
	end

	always_comb begin
		word = `IODR_RESET_WORD;
		word[FIELD_W-1:0] = data_reg;
		word[`IODR_BIT_NEW] = new_reg;
		word[`IODR_BIT_ERR] = alarm;
	end

endmodule

// ===== logic/iodr_pressure_low.sv
`timescale 1ns/10ps
`include "iodr_consts.svh"

module iodr_pressure_low
	import iodr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sample side
	input wire logic load,
	input wire logic [`IODR_W8-1:0] field,
	// Formatted word
	output iodr_word_t word
);

	logic [`IODR_W8-1:0] frac_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			frac_reg <= '0;
		end else if (load) begin
			frac_reg <= field;
		end
	end

	assign word = {8'h00, frac_reg};

endmodule

// ===== logic/iodr_top.sv
`timescale 1ns/10ps
`include "iodr_consts.svh"

// Operation
// - Top bit flags unread new sample in every word but pressure low
// - Bit 14 shows any active alarm in every word but pressure low
// - Accel words: 14-bit signed, 3.33 milli-g
// - Plus/minus 18 g map to 0x1519/0x2ae7
// - Magnetometer words: 14-bit signed, half milligauss
// - Plus/minus 2.5 gauss give 0x1388/0x2c78
// - Pressure high: unsigned 14-bit, 0.08 mbar
// - Pressure low: 8-bit fraction, upper byte zero
// - 1200/1000 mbar give 0x3a98/0x30d4
// - Temperature: 12-bit signed about 25 C
// - 105/-40 C give 0x24c/0xe22
// - Supply: unsigned 12-bit, 2.418 mV steps
// - 5.0/4.75 V give 0x814/0x7ac
// - Output registers ignore host writes
module iodr_top
	import iodr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sensor front end, codes already scaled
	input wire logic sample_valid,
	input iodr_sample_s sample,
	input wire logic alarm_active,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest
);

	//--------------------------------------------------------------
	// Address decode
	//--------------------------------------------------------------

	function automatic iodr_chan_e decode(input logic [7:0] addr);
		case (addr)
			`IODR_IDX_SUPPLY: decode = IODR_CH_SUPPLY;
			`IODR_IDX_ACCEL_Y: decode = IODR_CH_ACCEL_Y;
			`IODR_IDX_ACCEL_Z: decode = IODR_CH_ACCEL_Z;
			`IODR_IDX_MAG_X: decode = IODR_CH_MAG_X;
			`IODR_IDX_MAG_Y: decode = IODR_CH_MAG_Y;
			`IODR_IDX_MAG_Z: decode = IODR_CH_MAG_Z;
			`IODR_IDX_PRESS_HIGH: decode = IODR_CH_PRESS_HIGH;
			`IODR_IDX_PRESS_LOW: decode = IODR_CH_PRESS_LOW;
			`IODR_IDX_TEMP: decode = IODR_CH_TEMP;
			default: decode = IODR_CH_NONE;
		endcase
	endfunction

	//--------------------------------------------------------------
	// Bus state machine
	//--------------------------------------------------------------

	iodr_state_e state_reg;
	iodr_avm_req_s req;
	iodr_chan_e chan;
	logic take;
	logic rd_done;

	assign req = '{address: avs_address, read: avs_read, write: avs_write,
		writedata: avs_writedata, byteenable: avs_byteenable};
	assign chan = decode(req.address);
	assign take = (state_reg == IODR_ST_WAIT);
	assign rd_done = take && req.read;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= IODR_ST_IDLE;
		end else begin
			case (state_reg)
				IODR_ST_IDLE: begin
					if (req.read || req.write) begin
						state_reg <= IODR_ST_WAIT;
					end
				end
				IODR_ST_WAIT: state_reg <= IODR_ST_DONE;
				IODR_ST_DONE: state_reg <= IODR_ST_IDLE;
				default: state_reg <= IODR_ST_IDLE;
			endcase
		end
	end

	//--------------------------------------------------------------
	// Output words
	//--------------------------------------------------------------

	iodr_word_t words [0:8];
	logic [8:0] read_hit;

	always_comb begin
		read_hit = '0;
		if (rd_done && chan != IODR_CH_NONE) begin
			read_hit[chan] = 1'b1;
		end
	end

	// Codes arrive already scaled; the fields pass them bit for bit
	iodr_word_fmt #(.FIELD_W(`IODR_W12)) u_supply (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.supply),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_SUPPLY]),
		.word(words[IODR_CH_SUPPLY])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W14)) u_accel_y (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.accel_y),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_ACCEL_Y]),
		.word(words[IODR_CH_ACCEL_Y])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W14)) u_accel_z (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.accel_z),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_ACCEL_Z]),
		.word(words[IODR_CH_ACCEL_Z])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W14)) u_mag_x (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.mag_x),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_MAG_X]),
		.word(words[IODR_CH_MAG_X])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W14)) u_mag_y (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.mag_y),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_MAG_Y]),
		.word(words[IODR_CH_MAG_Y])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W14)) u_mag_z (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.mag_z),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_MAG_Z]),
		.word(words[IODR_CH_MAG_Z])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W14)) u_press_high (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.pressure[21:8]),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_PRESS_HIGH]),
		.word(words[IODR_CH_PRESS_HIGH])
	);
	iodr_pressure_low u_press_low (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.pressure[7:0]),
		.word(words[IODR_CH_PRESS_LOW])
	);
	iodr_word_fmt #(.FIELD_W(`IODR_W12)) u_temp (
		.clk(clk), .rst(rst), .load(sample_valid),
		.field(sample.temperature),
		.alarm(alarm_active), .read_ack(read_hit[IODR_CH_TEMP]),
		.word(words[IODR_CH_TEMP])
	);

	//--------------------------------------------------------------
	// Bus answer
	//--------------------------------------------------------------

	always_ff @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(take && (req.read || req.write));
		end
	end

	// Writes are accepted and dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= '0;
			avs_response <= 2'h0;
		end else if (take) begin
			if (chan == IODR_CH_NONE) begin
				avs_readdata <= '0;
				avs_response <= 2'h3;
			end else begin
				avs_readdata <= req.read ? {16'h0000, words[chan]} : 32'h00000000;
				avs_response <= 2'h0;
			end
		end
	end

endmodule

// ===== dv/iodr_asserts.sv
`timescale 1ns/10ps
module iodr_asserts
	import iodr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic alarm_active,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire req = avs_read | avs_write;
	wire ack = !avs_waitrequest;
	wire rda = ack && avs_read;
	wire map = avs_address inside {8'h02, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a};
	sequence s_two;
		avs_waitrequest ##1 avs_waitrequest ##1 ack;
	endsequence
	a_answer_two: assert property ($rose(req) |-> s_two) else $error("answer off time");
	a_ack_once: assert property (ack |=> avs_waitrequest) else $error("ack too long");
	a_idle_wait: assert property (!req |-> avs_waitrequest) else $error("ack without request");
	a_resp_code: assert property (ack |-> avs_response == (map ? 2'b00 : 2'b11))
		else $error("bad response");
	a_unmap_zero: assert property (rda && !map |-> avs_readdata == 32'h0) else $error("unmapped data");
	a_high_zero: assert property (ack |-> avs_readdata[31:16] == 16'h0) else $error("upper half set");
	a_spare_bits: assert property (rda && avs_address inside {8'h02, 8'h1a} |->
		avs_readdata[13:12] == 2'b00) else $error("spare bits set");
	a_low_upper: assert property (rda && avs_address == 8'h18 |->
		avs_readdata[15:8] == 8'h00) else $error("low word upper byte set");
	a_alarm_bit: assert property (rda && map && avs_address != 8'h18 &&
		$stable(alarm_active) && $past(alarm_active, 2) == alarm_active |->
		avs_readdata[14] == alarm_active) else $error("alarm bit wrong");
	a_reset_idle: assert property ($fell(rst) |-> avs_waitrequest && avs_readdata == 32'h0)
		else $error("not idle after reset");
endmodule

bind iodr_top iodr_asserts u_iodr_asserts (.clk, .rst, .alarm_active, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_response, .avs_waitrequest);

// ===== dv/iodr_host.sv
`timescale 1ns/10ps
module iodr_host
	import iodr_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bus master side
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest
);
	initial {avs_address, avs_read, avs_write} = '0;
	// Request held until waitrequest sampled low
	task automatic xfer(input logic w, input logic [7:0] a, output logic [15:0] d,
		output logic [1:0] r);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		d = avs_readdata[15:0];
		r = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic press(output logic [23:0] p);
		logic [15:0] h;
		logic [15:0] l;
		logic [1:0] r;
		xfer(1'b0, 8'h16, h, r);
		xfer(1'b0, 8'h18, l, r);
		p = ({10'h0, h[13:0]} << 8) + {16'h0, l[7:0]};
	endtask
endmodule

// ===== dv/iodr_top_tb_top.sv
`timescale 1ns/10ps
module iodr_top_tb_top
	import iodr_pkg::*;
;
	logic clk, rst, sample_valid, alarm_active, avs_read, avs_write, avs_waitrequest;
	iodr_sample_s sample;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata = 32'h0000ffff;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic [1:0] avs_response;
	int n_mismatch = 0;
	int num_checks = 0;
	localparam logic [7:0] AL [9] = '{8'h02, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a};
	iodr_top u_iodr_top (.clk, .rst, .sample_valid, .sample, .alarm_active, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response,
		.avs_waitrequest);
	iodr_host u_iodr_host (.clk, .avs_address, .avs_read, .avs_write, .avs_readdata,
		.avs_response, .avs_waitrequest);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task chk(input logic [23:0] s, input logic [23:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	function automatic logic [15:0] expw(logic [7:0] a, iodr_sample_s s, logic al, logic nf);
		case (a)
			8'h02: return {nf, al, 2'b00, s.supply};
			8'h0c: return {nf, al, s.accel_y};
			8'h0e: return {nf, al, s.accel_z};
			8'h10: return {nf, al, s.mag_x};
			8'h12: return {nf, al, s.mag_y};
			8'h14: return {nf, al, s.mag_z};
			8'h16: return {nf, al, s.pressure[21:8]};
			8'h18: return {8'h00, s.pressure[7:0]};
			default: return {nf, al, 2'b00, s.temperature};
		endcase
	endfunction
	task ld(input iodr_sample_s s, input logic al);
		sample <= s;
		sample_valid <= 1'b1;
		alarm_active <= al;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(posedge clk);
	endtask
	task rdall(input iodr_sample_s s, input logic al, input logic nf);
		logic [15:0] d;
		logic [1:0] r;
		foreach (AL[i]) begin
			u_iodr_host.xfer(1'b0, AL[i], d, r);
			chk(24'(d), 24'(expw(AL[i], s, al, nf)));
			chk(24'(r), 24'h0);
		end
	endtask
	task t_bounds;
		iodr_sample_s s;
		logic [23:0] p;
		s = '{14'h1519, 14'h2ae7, 14'h1388, 14'h2c78, 14'h0, {14'h3a98, 8'h5a}, 12'h24c, 12'h814};
		ld(s, 1'b0);
		rdall(s, 1'b0, 1'b1);
		rdall(s, 1'b0, 1'b0);
		u_iodr_host.press(p);
		chk(p, 24'h3a985a);
		$display("t_bounds done");
	endtask
	task t_alarm;
		iodr_sample_s s;
		s = '{14'h3fff, 14'h1, 14'h3ffe, 14'h2, 14'h2c78, {14'h30d4, 8'hff}, 12'he22, 12'h7ac};
		ld(s, 1'b1);
		rdall(s, 1'b1, 1'b1);
		alarm_active <= 1'b0;
		repeat (2) @(posedge clk);
		rdall(s, 1'b0, 1'b0);
		$display("t_alarm done");
	endtask
	task t_write;
		logic [15:0] d;
		logic [1:0] r;
		ld('0, 1'b0);
		foreach (AL[i]) begin
			u_iodr_host.xfer(1'b1, AL[i], d, r);
			chk(24'(r), 24'h0);
		end
		rdall('0, 1'b0, 1'b1);
		u_iodr_host.xfer(1'b1, 8'h1c, d, r);
		chk(24'(r), 24'h3);
		u_iodr_host.xfer(1'b0, 8'h04, d, r);
		chk(24'({r, d}), 24'h30000);
		$display("t_write done");
	endtask
	// Sample load lands on the edge where the read clears the flag
	task t_race;
		logic [15:0] d;
		logic [1:0] r;
		fork
			u_iodr_host.xfer(1'b0, 8'h0c, d, r);
			begin
				@(posedge clk);
				sample_valid <= 1'b1;
				@(posedge clk);
				sample_valid <= 1'b0;
			end
		join
		chk(24'(d), 24'h0);
		u_iodr_host.xfer(1'b0, 8'h0c, d, r);
		chk(24'(d), 24'h8000);
		$display("t_race done");
	endtask
	// Mid-run reset clears data and flags
	task t_reset;
		ld('1, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdall('0, 1'b0, 1'b0);
		$display("t_reset done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{rst, sample_valid, alarm_active} <= 3'b100;
		sample <= '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdall('0, 1'b0, 1'b0);
		t_bounds;
		t_alarm;
		t_write;
		t_race;
		t_reset;
		final_report;
	end
	initial begin
		#200000;
		n_mismatch++;
		final_report;
	end
endmodule
